// ==== hw/pst_defs.svh ====
// Purpose: offsets, field positions, reset values of the time-stamp unit
// Assumes: 16-bit register address, 32-bit data
// Notes: definitions only
`ifndef PST_DEFS_SVH
`define PST_DEFS_SVH
// register offsets
`define PST_OFS_SYS_LO    16'hB600
`define PST_OFS_SYS_HI    16'hB604
`define PST_OFS_INC       16'hB608
`define PST_OFS_ADJ_LO    16'hB60C
`define PST_OFS_ADJ_HI    16'hB610
`define PST_OFS_TX_CTL    16'hB614
`define PST_OFS_STAMP_LO  16'hB618
`define PST_OFS_STAMP_HI  16'hB61C
`define PST_OFS_UDP       16'hB638
`define PST_OFS_IRQ_STAT  16'hB640
`define PST_OFS_IRQ_MASK  16'hB644
// field positions
`define PST_BIT_VALID     0
`define PST_BIT_EN        4
`define PST_BIT_PKT       5
`define PST_BIT_SIGN      31
`define PST_BIT_EV_CAP    0
`define PST_BIT_EV_MISS   1
// reset values
`define PST_RST_UDP       16'h0319
`define PST_RST_ZERO32    32'h0000_0000
`endif

// ==== hw/pst_pkg.sv ====
// Purpose: state types of the time-stamp unit
// Assumes: pst_defs.svh holds all numbers
// Notes: one packed struct per stateful module, none for pst_time_calc
package pst_pkg;
    // whole state of the top module
    typedef struct packed {
        logic [63:0] sysTime;
        logic [23:0] incValue;
        logic [7:0]  incPeriod;
        logic [31:0] adjLow;
        logic [31:0] adjHigh;
        logic        adjPend;
        logic        txEn;
        logic        pktMode;
        logic        txValid;
        logic [31:0] stampLow;
        logic [31:0] stampHigh;
        logic [15:0] udpPort;
        logic [1:0]  irqStat;
        logic [1:0]  irqMask;
        logic [31:0] rdData;
    } pst_state_t;
    // state of the period divider
    typedef struct packed {
        logic [7:0] cnt;
    } pst_tick_t;
endpackage

// ==== hw/pst_period_tick.sv ====
// Purpose: one-cycle advance enable every period clocks
// Assumes: period of zero means no advance
// Notes: counter restarts when stopped
`timescale 1ns/100ps
module pst_period_tick (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       run,
    input  wire logic [7:0] period,
    output logic            tick
);
    import pst_pkg::*;
    pst_tick_t s_q;  // registered state
    pst_tick_t s_d;  // next state
    // pulse on the last count of the period
    assign tick = run && (period != 8'h00) && (s_q.cnt >= period - 8'h01);
    // next count
    always_comb begin
        s_d = s_q;
        if (!run || tick) begin
            s_d.cnt = 8'h00;  // restart, also after a smaller period is written
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end
    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // pst_period_tick

// ==== hw/pst_time_calc.sv ====
// Purpose: next system time from increment and signed adjustment
// Assumes: both terms may apply in the same cycle
// Notes: purely combinational, wraps modulo 2^64
`timescale 1ns/100ps
`include "pst_defs.svh"
module pst_time_calc (
    input  wire logic [63:0] curTime,
    input  wire logic [23:0] incValue,
    input  wire logic        incEn,
    input  wire logic        adjEn,
    input  wire logic [31:0] adjLow,
    input  wire logic [31:0] adjHigh,
    output logic      [63:0] nextTime
);
    import pst_pkg::*;
    logic [63:0] mag;    // 63-bit adjust magnitude
    logic [63:0] delta;  // two's complement adjust term
    logic [63:0] inc;    // widened increment
    // sign bit selects add or subtract
    always_comb begin
        mag   = {1'b0, adjHigh[30:0], adjLow};
        delta = adjHigh[`PST_BIT_SIGN] ? (~mag + 64'h1) : mag;
        if (!adjEn) begin
            delta = 64'h0;
        end
        inc      = incEn ? {40'h0, incValue} : 64'h0;
        nextTime = curTime + inc + delta;
    end
endmodule // pst_time_calc

// ==== hw/pst_top.sv ====
// Purpose: system time keeper with transmit time stamp capture
// Assumes: capture strobe and udp port come from the transmit datapath
// Notes: registers on a plain strobe port, read data one cycle later
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "pst_defs.svh"
// Contract
// - udp port register, reset 0x0319, network order
// - capture sets valid; high-stamp read clears
// - control bit 4 enables transmit capture
// - packet mode adds increment per stamp
// - packet mode ignores increment period
// - adjust applied on next clock
// - stamp low/high read-only, reset zero
// - 64-bit system time, two words
// - increment value 23:0, period 31:24
// - adjust magnitude 63 bits, bit 31 sign
module pst_top (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    input  wire logic        txPktDone,
    input  wire logic        txIsUdp,
    input  wire logic [15:0] txUdpPort,
    output logic      [15:0] stampPortNumber,
    output logic      [63:0] systemTime,
    output logic             irq
);
    import pst_pkg::*;
    pst_state_t s_q;       // registered state
    pst_state_t s_d;       // next state
    logic       tick;      // normal mode advance enable
    logic       isEvent;   // qualifying transmit packet
    logic       capture;   // stamp taken this cycle
    logic       miss;      // event dropped, stamp still unread
    logic       incEn;     // increment applies this cycle
    logic       timeWr;    // software writes system time
    logic       hiRead;    // high stamp read
    logic       adjWr;     // adjust high word written
    logic [63:0] nextTime; // advanced system time

    // divider only runs in normal mode
    pst_period_tick u_tick (
        .clk    (clk),
        .arst_n (arst_n),
        .run    (!s_q.pktMode),
        .period (s_q.incPeriod),
        .tick   (tick)
    );

    // adder for increment and adjust
    pst_time_calc u_calc (
        .curTime  (s_q.sysTime),
        .incValue (s_q.incValue),
        .incEn    (incEn),
        .adjEn    (s_q.adjPend),
        .adjLow   (s_q.adjLow),
        .adjHigh  (s_q.adjHigh),
        .nextTime (nextTime)
    );

    // packet qualification, port compared in wire byte order
    assign isEvent = txPktDone && txIsUdp && (txUdpPort == s_q.udpPort);
    assign capture = isEvent && s_q.txEn && !s_q.txValid;
    assign miss    = isEvent && s_q.txEn && s_q.txValid;
    // advance source depends on mode
    assign incEn   = s_q.pktMode ? capture : tick;
    assign timeWr  = regWr && (regAddr == `PST_OFS_SYS_LO || regAddr == `PST_OFS_SYS_HI);
    assign hiRead  = regRd && (regAddr == `PST_OFS_STAMP_HI);
    assign adjWr   = regWr && (regAddr == `PST_OFS_ADJ_HI);

    // outputs from flops, irq masks the status flops through an AND-OR
    assign regRdData       = s_q.rdData;
    assign stampPortNumber = s_q.udpPort;
    assign systemTime      = s_q.sysTime;
    assign irq             = |(s_q.irqStat & s_q.irqMask);

    // next state: time, capture, registers, read data
    always_comb begin
        s_d = s_q;
        // time advance and adjust
        s_d.sysTime = nextTime;
        s_d.adjPend = 1'b0;                     // one-shot adjust
        // stamp capture takes the time before this cycle's advance
        if (capture) begin
            s_d.stampLow  = s_q.sysTime[31:0];
            s_d.stampHigh = s_q.sysTime[63:32];
        end
        // valid: set wins over the clearing read
        if (hiRead) begin
            s_d.txValid = 1'b0;
        end
        if (capture) begin
            s_d.txValid = 1'b1;
        end
        // software writes
        if (regWr) begin
            case (regAddr)
                `PST_OFS_SYS_LO: begin
                    s_d.sysTime[31:0] = regWrData;
                end
                `PST_OFS_SYS_HI: begin
                    s_d.sysTime[63:32] = regWrData;
                end
                `PST_OFS_INC: begin
                    s_d.incValue  = regWrData[23:0];
                    s_d.incPeriod = regWrData[31:24];
                end
                `PST_OFS_ADJ_LO: begin
                    s_d.adjLow = regWrData;
                end
                `PST_OFS_ADJ_HI: begin
                    s_d.adjHigh = regWrData;
                    s_d.adjPend = 1'b1;
                end
                `PST_OFS_TX_CTL: begin
                    s_d.txEn    = regWrData[`PST_BIT_EN];
                    s_d.pktMode = regWrData[`PST_BIT_PKT];
                end
                `PST_OFS_UDP: begin
                    s_d.udpPort = regWrData[15:0];
                end
                `PST_OFS_IRQ_MASK: begin
                    s_d.irqMask = regWrData[1:0];
                end
                `PST_OFS_IRQ_STAT: begin
                    s_d.irqStat = s_q.irqStat & ~regWrData[1:0];
                end
                default: begin
                    // unmapped or read-only: ignored
                end
            endcase
        end
        // events set after the clear so a coincident event survives
        if (capture) begin
            s_d.irqStat[`PST_BIT_EV_CAP] = 1'b1;
        end
        if (miss) begin
            s_d.irqStat[`PST_BIT_EV_MISS] = 1'b1;
        end
        // read data for the next cycle, zero when unmapped
        s_d.rdData = 32'h0000_0000;
        if (regRd) begin
            case (regAddr)
                `PST_OFS_SYS_LO:   s_d.rdData = s_q.sysTime[31:0];
                `PST_OFS_SYS_HI:   s_d.rdData = s_q.sysTime[63:32];
                `PST_OFS_INC:      s_d.rdData = {s_q.incPeriod, s_q.incValue};
                `PST_OFS_ADJ_LO:   s_d.rdData = s_q.adjLow;
                `PST_OFS_ADJ_HI:   s_d.rdData = s_q.adjHigh;
                `PST_OFS_TX_CTL:   s_d.rdData = {26'h0, s_q.pktMode, s_q.txEn, 3'h0, s_q.txValid};
                `PST_OFS_STAMP_LO: s_d.rdData = s_q.stampLow;
                `PST_OFS_STAMP_HI: s_d.rdData = s_q.stampHigh;
                `PST_OFS_UDP:      s_d.rdData = {16'h0, s_q.udpPort};
                `PST_OFS_IRQ_STAT: s_d.rdData = {30'h0, s_q.irqStat};
                `PST_OFS_IRQ_MASK: s_d.rdData = {30'h0, s_q.irqMask};
                default:           s_d.rdData = 32'h0000_0000;
            endcase
        end
    end

    // state register, constants only under reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q         <= '0;
            s_q.udpPort <= `PST_RST_UDP;
        end else begin
            s_q <= s_d;
        end
    end

    // adjust write as a named step
    sequence s_adjWrite;
        regWr && (regAddr == `PST_OFS_ADJ_HI);
    endsequence
    // quiet cycle: nothing but the adjust moves the time
    sequence s_adjOnly;
        s_q.adjPend && !incEn && !timeWr;
    endsequence

    property p_validSet;
        @(posedge clk) disable iff (!arst_n)
        capture |=> s_q.txValid;
    endproperty
    a_validSet: assert property (p_validSet) else $error("valid not set on capture");

    property p_validClr;
        @(posedge clk) disable iff (!arst_n)
        (hiRead && !capture) |=> !s_q.txValid;
    endproperty
    a_validClr: assert property (p_validClr) else $error("valid not cleared by read");

    property p_enGate;
        @(posedge clk) disable iff (!arst_n)
        (isEvent && !s_q.txEn) |=> $stable(s_q.stampLow) && !$rose(s_q.txValid);
    endproperty
    a_enGate: assert property (p_enGate) else $error("capture while disabled");

    property p_pktInc;
        @(posedge clk) disable iff (!arst_n)
        (s_q.pktMode && capture && !s_q.adjPend && !timeWr)
            |=> s_q.sysTime == $past(s_q.sysTime) + {40'h0, $past(s_q.incValue)};
    endproperty
    a_pktInc: assert property (p_pktInc) else $error("packet mode step wrong");

    property p_pktHold;
        @(posedge clk) disable iff (!arst_n)
        (s_q.pktMode && !capture && !s_q.adjPend && !timeWr) |=> $stable(s_q.sysTime);
    endproperty
    a_pktHold: assert property (p_pktHold) else $error("time moved in packet mode");

    property p_adjPend;
        @(posedge clk) disable iff (!arst_n)
        (s_adjWrite ##1 !adjWr) |-> s_q.adjPend ##1 !s_q.adjPend;
    endproperty
    a_adjPend: assert property (p_adjPend) else $error("adjust not one-shot");

    property p_adjApply;
        @(posedge clk) disable iff (!arst_n)
        (s_adjOnly and !s_q.adjHigh[`PST_BIT_SIGN]) |=> s_q.sysTime ==
            $past(s_q.sysTime) + {1'b0, $past(s_q.adjHigh[30:0]), $past(s_q.adjLow)};
    endproperty
    a_adjApply: assert property (p_adjApply) else $error("adjust add wrong");

    property p_normInc;
        @(posedge clk) disable iff (!arst_n)
        (!s_q.pktMode && !tick && !s_q.adjPend && !timeWr) |=> $stable(s_q.sysTime);
    endproperty
    a_normInc: assert property (p_normInc) else $error("time moved off period");

    property p_stampHold;
        @(posedge clk) disable iff (!arst_n)
        s_q.txValid && !hiRead |=> s_q.txValid && $stable(s_q.stampHigh);
    endproperty
    a_stampHold: assert property (p_stampHold) else $error("stamp overwritten");

    property p_stampRead;
        @(posedge clk) disable iff (!arst_n)
        regRd && (regAddr == `PST_OFS_STAMP_LO) |=> regRdData == $past(s_q.stampLow);
    endproperty
    a_stampRead: assert property (p_stampRead) else $error("stamp low read wrong");

    property p_portHold;
        @(posedge clk) disable iff (!arst_n)
        !(regWr && regAddr == `PST_OFS_UDP) |=> $stable(stampPortNumber);
    endproperty
    a_portHold: assert property (p_portHold) else $error("udp port changed");

    property p_incField;
        @(posedge clk) disable iff (!arst_n)
        regWr && (regAddr == `PST_OFS_INC) |=> s_q.incPeriod == $past(regWrData[31:24]);
    endproperty
    a_incField: assert property (p_incField) else $error("period field wrong");

    // capture as a named step, used by the stamp time check
    sequence s_capEvent;
        isEvent && s_q.txEn && !s_q.txValid;
    endsequence

    // stamp holds the time before this cycle's advance, not after it
    property p_captTime;
        @(posedge clk) disable iff (!arst_n)
        s_capEvent |=> s_q.stampLow == $past(s_q.sysTime[31:0])
            && s_q.stampHigh == $past(s_q.sysTime[63:32]);
    endproperty
    a_captTime: assert property (p_captTime) else $error("stamp not the current time");

    // a dropped event leaves the unread stamp alone and flags the loss
    property p_missHold;
        @(posedge clk) disable iff (!arst_n)
        miss |=> $stable(s_q.stampLow) && $stable(s_q.stampHigh)
            && s_q.irqStat[`PST_BIT_EV_MISS];
    endproperty
    a_missHold: assert property (p_missHold) else $error("missed event not flagged");

    // capture raises its status bit
    property p_capFlag;
        @(posedge clk) disable iff (!arst_n)
        capture |=> s_q.irqStat[`PST_BIT_EV_CAP];
    endproperty
    a_capFlag: assert property (p_capFlag) else $error("capture status not set");

    // negative adjust, only in a cycle with nothing else moving the time
    property p_adjSub;
        @(posedge clk) disable iff (!arst_n)
        (s_adjOnly and s_q.adjHigh[`PST_BIT_SIGN]) |=> s_q.sysTime ==
            $past(s_q.sysTime) - {1'b0, $past(s_q.adjHigh[30:0]), $past(s_q.adjLow)};
    endproperty
    a_adjSub: assert property (p_adjSub) else $error("adjust subtract wrong");

    // one increment per divider pulse in normal mode
    property p_normTick;
        @(posedge clk) disable iff (!arst_n)
        (!s_q.pktMode && tick && !s_q.adjPend && !timeWr)
            |=> s_q.sysTime == $past(s_q.sysTime) + {40'h0, $past(s_q.incValue)};
    endproperty
    a_normTick: assert property (p_normTick) else $error("period step wrong");

    // increment value field lands in the low bits
    property p_incValue;
        @(posedge clk) disable iff (!arst_n)
        regWr && (regAddr == `PST_OFS_INC) |=> s_q.incValue == $past(regWrData[23:0]);
    endproperty
    a_incValue: assert property (p_incValue) else $error("increment field wrong");

    // software write of the low word wins over the advance
    property p_sysWrLow;
        @(posedge clk) disable iff (!arst_n)
        regWr && (regAddr == `PST_OFS_SYS_LO) |=> s_q.sysTime[31:0] == $past(regWrData);
    endproperty
    a_sysWrLow: assert property (p_sysWrLow) else $error("time low write lost");

    // software write of the high word wins over the advance
    property p_sysWrHigh;
        @(posedge clk) disable iff (!arst_n)
        regWr && (regAddr == `PST_OFS_SYS_HI) |=> s_q.sysTime[63:32] == $past(regWrData);
    endproperty
    a_sysWrHigh: assert property (p_sysWrHigh) else $error("time high write lost");

    // port register written as given, no byte swap
    property p_portWrite;
        @(posedge clk) disable iff (!arst_n)
        regWr && (regAddr == `PST_OFS_UDP) |=> stampPortNumber == $past(regWrData[15:0]);
    endproperty
    a_portWrite: assert property (p_portWrite) else $error("udp port write lost");

    // stamp words ignore software writes
    property p_stampRo;
        @(posedge clk) disable iff (!arst_n)
        (regWr && (regAddr == `PST_OFS_STAMP_LO || regAddr == `PST_OFS_STAMP_HI) && !capture)
            |=> $stable(s_q.stampLow) && $stable(s_q.stampHigh);
    endproperty
    a_stampRo: assert property (p_stampRo) else $error("stamp written by software");

    // high stamp read returns the held word
    property p_stampHiRead;
        @(posedge clk) disable iff (!arst_n)
        hiRead |=> regRdData == $past(s_q.stampHigh);
    endproperty
    a_stampHiRead: assert property (p_stampHiRead) else $error("stamp high read wrong");

    // enable and packet mode follow their control bits
    property p_ctrlWrite;
        @(posedge clk) disable iff (!arst_n)
        regWr && (regAddr == `PST_OFS_TX_CTL) |=> s_q.txEn == $past(regWrData[`PST_BIT_EN])
            && s_q.pktMode == $past(regWrData[`PST_BIT_PKT]);
    endproperty
    a_ctrlWrite: assert property (p_ctrlWrite) else $error("control bits wrong");
endmodule // pst_top

// ==== testbench/pst_tx_model.sv ====
// Purpose: transmit datapath stand-in that raises the capture strobe
// Assumes: one packet per request, outputs change just after the edge
// Notes: idle qualifiers toggle every cycle so stale values never pass
`timescale 1ns/100ps
module pst_tx_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        send,      // request one packet
    input  wire logic        isUdp,     // packet kind
    input  wire logic [15:0] port,      // dest port, wire order
    output logic             txPktDone,
    output logic             txIsUdp,
    output logic      [15:0] txUdpPort
);
    // one-cycle done pulse, qualifiers only meaningful beside it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txPktDone <= 1'b0;
            txIsUdp   <= 1'b0;
            txUdpPort <= 16'h0000;
        end else if (send) begin
            txPktDone <= 1'b1;
            txIsUdp   <= isUdp;
            txUdpPort <= port;
        end else begin
            // released lines keep moving, never the last value
            txPktDone <= 1'b0;
            txIsUdp   <= ~txIsUdp;
            txUdpPort <= ~txUdpPort;
        end
    end
endmodule // pst_tx_model

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the time-stamp unit
// Assumes: period 0 stops clock advance, stamp high read clears valid
// Notes: expectations come from written values and sampled system time
`timescale 1ns/100ps
`include "pst_defs.svh"
module tb_top;
    import pst_pkg::*;
    logic        clk, arst_n, regWr, regRd, send, isUdp, irq;
    logic        txPktDone, txIsUdp;
    logic [15:0] regAddr, port, txUdpPort, stampPortNumber, pn;
    logic [31:0] regWrData, regRdData, v;
    logic [63:0] systemTime, t0, a;
    logic [7:0]  p;
    int          n_mismatch, check_count, seed, cyc, i;
    logic [15:0] ofs [12] = '{16'hB600, 16'hB604, 16'hB608, 16'hB60C, 16'hB610, 16'hB614,
                              16'hB618, 16'hB61C, 16'hB638, 16'hB640, 16'hB644, 16'hB620};

    pst_top dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txPktDone(txPktDone),
        .txIsUdp(txIsUdp), .txUdpPort(txUdpPort), .stampPortNumber(stampPortNumber),
        .systemTime(systemTime), .irq(irq));
    pst_tx_model txm (.clk(clk), .arst_n(arst_n), .send(send), .isUdp(isUdp), .port(port),
        .txPktDone(txPktDone), .txIsUdp(txIsUdp), .txUdpPort(txUdpPort));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard, run needs a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chkReg(string nm, logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic chkTime(string nm, logic [63:0] got, logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask

    // expected time after a signed adjust
    function automatic logic [63:0] expAdj(logic [63:0] t, logic [63:0] m, logic s);
        return s ? t - m : t + m;
    endfunction

    // expected advance after n increments
    function automatic logic [63:0] expAdv(int n, logic [23:0] inc);
        return 64'(n) * {40'h0, inc};
    endfunction

    // one write strobe, then a quiet edge
    task automatic wr(logic [15:0] ad, logic [31:0] d);
        regWr <= 1'b1; regAddr <= ad; regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(logic [15:0] ad, logic [31:0] exp);
        regRd <= 1'b1; regAddr <= ad;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chkReg("regRdData", regRdData, exp);
        @(posedge clk);
    endtask

    // packet through the model, capture lands two edges later
    task automatic pkt(logic u, logic [15:0] pp);
        send <= 1'b1; isUdp <= u; port <= pp;
        @(posedge clk);
        send <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        seed = 32'h1DFD9DA7;
        clk = 0; arst_n = 0; regWr = 0; regRd = 0; regAddr = 0; regWrData = 0;
        send = 0; isUdp = 0; port = 0; n_mismatch = 0; check_count = 0; cyc = 0;
        repeat (12) @(posedge clk);
        chkTime("systemTime", systemTime, 64'h0);
        chkReg("stampPortNumber", {16'h0, stampPortNumber}, 32'h0319);
        arst_n <= 1'b1;
        @(posedge clk);
        // reset table, unmapped place last
        for (i = 0; i < 12; i++) rd(ofs[i], (i == 8) ? 32'h0319 : 32'h0);
        v = $random(seed);
        wr(`PST_OFS_ADJ_LO, v); rd(`PST_OFS_ADJ_LO, v);
        wr(`PST_OFS_ADJ_HI, ~v); rd(`PST_OFS_ADJ_HI, ~v);
        // normal advance: N periods give exactly N adds whatever the phase
        for (i = 0; i < 5; i++) begin
            p = (i == 0) ? 8'h00 : 8'({$random(seed)} % 8 + 1);
            v = $random(seed);
            wr(`PST_OFS_INC, {p, v[23:0]}); rd(`PST_OFS_INC, {p, v[23:0]});
            repeat (p + 2) @(posedge clk);
            #1 t0 = systemTime;
            repeat ((p == 0) ? 20 : 5 * p) @(posedge clk);
            #1 chkTime("advance", systemTime - t0, expAdv((p == 0) ? 0 : 5, v[23:0]));
        end
        // adjust both signs in both modes, clock advance stopped
        wr(`PST_OFS_INC, 32'h0000_0123);
        for (i = 0; i < 4; i++) begin
            wr(`PST_OFS_TX_CTL, {26'h0, i[1], 5'h0});
            t0 = {$random(seed), $random(seed)};
            a = {$random(seed), $random(seed)} & 64'h7FFF_FFFF_FFFF_FFFF;
            wr(`PST_OFS_SYS_LO, t0[31:0]); wr(`PST_OFS_SYS_HI, t0[63:32]);
            rd(`PST_OFS_SYS_LO, t0[31:0]); rd(`PST_OFS_SYS_HI, t0[63:32]);
            wr(`PST_OFS_ADJ_LO, a[31:0]); wr(`PST_OFS_ADJ_HI, {i[0], a[62:32]});
            #1 chkTime("adjust", systemTime, expAdj(t0, a, i[0]));
        end
        // packet mode capture, period set but meaningless
        pn = 16'($random(seed));
        wr(`PST_OFS_UDP, {16'hFFFF, pn}); rd(`PST_OFS_UDP, {16'h0, pn});
        chkReg("stampPortNumber", {16'h0, stampPortNumber}, {16'h0, pn});
        v = $random(seed);
        wr(`PST_OFS_INC, {8'h03, v[23:0]}); wr(`PST_OFS_TX_CTL, 32'h30);
        #1 t0 = systemTime;
        repeat (20) @(posedge clk);
        #1 chkTime("pktHold", systemTime, t0);
        pkt(1'b1, pn);
        chkTime("pktAdvance", systemTime, t0 + v[23:0]);
        chkReg("irq", {31'h0, irq}, 32'h0);
        wr(`PST_OFS_IRQ_MASK, 32'h1);
        #1 chkReg("irq", {31'h0, irq}, 32'h1);
        rd(`PST_OFS_TX_CTL, 32'h31);
        pkt(1'b1, pn);
        chkTime("missNoAdvance", systemTime, t0 + v[23:0]);
        rd(`PST_OFS_IRQ_STAT, 32'h3);
        wr(`PST_OFS_STAMP_LO, ~t0[31:0]);
        rd(`PST_OFS_STAMP_LO, t0[31:0]); rd(`PST_OFS_STAMP_HI, t0[63:32]);
        rd(`PST_OFS_TX_CTL, 32'h30);
        wr(`PST_OFS_IRQ_STAT, 32'h3);
        chkReg("irq", {31'h0, irq}, 32'h0);
        // refused: wrong port, not udp, capture disabled
        pkt(1'b1, ~pn); pkt(1'b0, pn);
        wr(`PST_OFS_TX_CTL, 32'h20); pkt(1'b1, pn);
        chkTime("noCapture", systemTime, t0 + v[23:0]);
        rd(`PST_OFS_TX_CTL, 32'h20);
        // normal mode capture takes the current time
        wr(`PST_OFS_INC, 32'h0); wr(`PST_OFS_TX_CTL, 32'h10);
        #1 t0 = systemTime;
        pkt(1'b1, pn);
        rd(`PST_OFS_STAMP_LO, t0[31:0]); rd(`PST_OFS_STAMP_HI, t0[63:32]);
        rd(`PST_OFS_TX_CTL, 32'h10);
        test_done();
    end
endmodule // tb_top
